// ---- hw/dpt_pkg.sv ----
// Constants and types for the DMA page and cycle timing register bank.
// Assumes an I/O-space access port with a 16-bit address and 8-bit data.
package dpt_pkg;

    // Port widths.
    localparam int IO_ADDR_W = 16;
    localparam int DATA_W    = 8;
    localparam int NUM_CH    = 8;

    // Low page registers, system address bits 23 to 16.
    localparam logic [15:0] ADDR_LOW_CH2 = 16'h0081;
    localparam logic [15:0] ADDR_LOW_CH3 = 16'h0082;
    localparam logic [15:0] ADDR_LOW_CH1 = 16'h0083;
    localparam logic [15:0] ADDR_LOW_CH0 = 16'h0087;
    localparam logic [15:0] ADDR_LOW_CH6 = 16'h0089;
    localparam logic [15:0] ADDR_LOW_CH7 = 16'h008A;
    localparam logic [15:0] ADDR_LOW_CH5 = 16'h008B;

    // High page registers, system address bits 31 to 24.
    localparam logic [15:0] ADDR_HIGH_CH2 = 16'h0481;
    localparam logic [15:0] ADDR_HIGH_CH3 = 16'h0482;
    localparam logic [15:0] ADDR_HIGH_CH1 = 16'h0483;
    localparam logic [15:0] ADDR_HIGH_CH0 = 16'h0487;
    localparam logic [15:0] ADDR_HIGH_CH6 = 16'h0489;
    localparam logic [15:0] ADDR_HIGH_CH7 = 16'h048A;
    localparam logic [15:0] ADDR_HIGH_CH5 = 16'h048B;

    // Write-only extended timing registers.
    localparam logic [15:0] ADDR_BYTE_EXT_TIMING = 16'h040B;
    localparam logic [15:0] ADDR_WORD_EXT_TIMING = 16'h04D6;

    // Extended timing register field layout.
    localparam int EXT_SEL_LSB  = 0;
    localparam int EXT_SEL_W    = 4;
    localparam int EXT_MODE_LSB = 4;
    localparam int EXT_MODE_W   = 2;

    // Reset values.
    localparam logic [7:0] PAGE_RESET     = 8'h00;
    localparam logic [7:0] EXT_RESET      = 8'h00;
    localparam logic [7:0] READ_UNDEFINED = 8'h00;

    // Cycle timing modes, encoded as in bits 5:4.
    typedef enum logic [1:0] {
        DPT_TIMING_COMPAT = 2'h0,
        DPT_TIMING_A      = 2'h1,
        DPT_TIMING_B      = 2'h2,
        DPT_TIMING_F      = 2'h3
    } dpt_timing_t;

endpackage : dpt_pkg

// ---- hw/dpt_timing_unit.sv ----
// Per-controller extended timing register: four channel selects and a mode.
// Assumes a one-cycle write strobe already decoded for this controller.
`timescale 1ns/1ns
module dpt_timing_unit (
    input  wire logic                I_SYS_CLK,
    input  wire logic                i_reset,
    input  wire logic                i_write,
    input  wire logic [7:0]          i_data,
    output logic      [3:0]          o_select,
    output dpt_pkg::dpt_timing_t     o_mode,
    output logic      [7:0]          o_channel_timing
);

    typedef struct packed {
        logic [3:0] select;
        logic [1:0] mode;
        logic [7:0] chan;
    } dpt_tu_state_t;

    dpt_tu_state_t state;
    dpt_tu_state_t next_state;

    // Selected channels take the written mode, the others keep theirs.
    always_comb begin
        next_state = state;
        if (i_write) begin
            next_state.select = i_data[dpt_pkg::EXT_SEL_LSB +: dpt_pkg::EXT_SEL_W]; // R10
            next_state.mode   = i_data[dpt_pkg::EXT_MODE_LSB +: dpt_pkg::EXT_MODE_W]; // R9
            for (int c = 0; c < 4; c++) begin
                if (i_data[dpt_pkg::EXT_SEL_LSB + c]) begin
                    next_state.chan[2*c +: 2] = i_data[dpt_pkg::EXT_MODE_LSB +: 2]; // R13
                end
            end
        end
    end

    // Reset brings every channel back to compatible timing.
    always_ff @(posedge I_SYS_CLK) begin
        if (i_reset) begin
            state <= '{select: dpt_pkg::EXT_RESET[3:0], mode: dpt_pkg::EXT_RESET[5:4],
                       chan: dpt_pkg::EXT_RESET}; // R12
        end else begin
            state <= next_state;
        end
    end

    assign o_select         = state.select;
    assign o_mode           = dpt_pkg::dpt_timing_t'(state.mode);
    assign o_channel_timing = state.chan;

endmodule : dpt_timing_unit

// ---- hw/dpt_regs.sv ----
// DMA page and cycle timing register bank for both legacy DMA controllers.
// Assumes single-cycle I/O strobes synchronous to I_SYS_CLK and a transfer
// engine that names the active channel (0 to 7) while it moves data.
//
// Operation
// R1 - Low page drives address bits 23-16
// R2 - High page drives address bits 31-24
// R3 - Word unit low pages at 089-08B
// R4 - Byte unit high pages at 481-487
// R5 - Word unit high pages at 489-48B
// R6 - Page registers eight-bit read-write, reset zero
// R7 - Byte unit timing register write-only at 40B
// R8 - Word unit timing register write-only at 4D6
// R9 - Bits 5:4 choose timing mode
// R10 - Byte unit bits 0-3 select channels 0-3
// R11 - Word unit bits 0-3 select channels 4-7
// R12 - Processor reset clears both timing registers
// R13 - Written mode applies only to selected channels
`timescale 1ns/1ns
module dpt_regs #(
    parameter int NUM_CH = dpt_pkg::NUM_CH
) (
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_SYS_RST,
    input  wire logic                          i_host_processor_reset,
    input  wire logic [dpt_pkg::IO_ADDR_W-1:0] i_io_addr,
    input  wire logic                          i_io_write,
    input  wire logic                          i_io_read,
    input  wire logic [dpt_pkg::DATA_W-1:0]    i_io_wdata,
    input  wire logic [2:0]                    i_active_channel,
    input  wire logic                          i_transfer_active,
    output logic      [dpt_pkg::DATA_W-1:0]    o_io_rdata,
    output logic                               o_io_hit,
    output logic      [15:0]                   o_dma_addr_high,
    output logic      [3:0]                    o_byte_wide_dma_unit_select,
    output dpt_pkg::dpt_timing_t               o_byte_wide_dma_unit_mode,
    output logic      [3:0]                    o_word_wide_dma_unit_select,
    output dpt_pkg::dpt_timing_t               o_word_wide_dma_unit_mode,
    output logic      [2*NUM_CH-1:0]           o_channel_timing
);

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] low_page;
        logic [NUM_CH-1:0][7:0] high_page;
        logic [7:0]             rdata;
        logic                   hit;
        logic [15:0]            addr_high;
    } dpt_regs_state_t;

    dpt_regs_state_t state;
    dpt_regs_state_t next_state;

    logic ext_reset;
    logic byte_ext_write;
    logic word_ext_write;

    // Channel index of a low page address; returns NUM_CH for no match.
    // Channel 4 is the cascade link and has no page register here.
    function automatic logic [3:0] low_page_index(input logic [15:0] addr);
        case (addr)
            dpt_pkg::ADDR_LOW_CH0: low_page_index = 4'h0;
            dpt_pkg::ADDR_LOW_CH1: low_page_index = 4'h1;
            dpt_pkg::ADDR_LOW_CH2: low_page_index = 4'h2;
            dpt_pkg::ADDR_LOW_CH3: low_page_index = 4'h3;
            dpt_pkg::ADDR_LOW_CH5: low_page_index = 4'h5; // R3
            dpt_pkg::ADDR_LOW_CH6: low_page_index = 4'h6; // R3
            dpt_pkg::ADDR_LOW_CH7: low_page_index = 4'h7; // R3
            default:               low_page_index = 4'h8;
        endcase
    endfunction : low_page_index

    // Channel index of a high page address; returns NUM_CH for no match.
    function automatic logic [3:0] high_page_index(input logic [15:0] addr);
        case (addr)
            dpt_pkg::ADDR_HIGH_CH0: high_page_index = 4'h0; // R4
            dpt_pkg::ADDR_HIGH_CH1: high_page_index = 4'h1; // R4
            dpt_pkg::ADDR_HIGH_CH2: high_page_index = 4'h2; // R4
            dpt_pkg::ADDR_HIGH_CH3: high_page_index = 4'h3; // R4
            dpt_pkg::ADDR_HIGH_CH5: high_page_index = 4'h5; // R5
            dpt_pkg::ADDR_HIGH_CH6: high_page_index = 4'h6; // R5
            dpt_pkg::ADDR_HIGH_CH7: high_page_index = 4'h7; // R5
            default:                high_page_index = 4'h8;
        endcase
    endfunction : high_page_index

    // Timing registers clear on either reset; page registers only on system reset.
    assign ext_reset      = I_SYS_RST | i_host_processor_reset; // R12
    assign byte_ext_write = i_io_write & (i_io_addr == dpt_pkg::ADDR_BYTE_EXT_TIMING); // R7
    assign word_ext_write = i_io_write & (i_io_addr == dpt_pkg::ADDR_WORD_EXT_TIMING); // R8

    // Register writes, read data and the page address for the active channel.
    always_comb begin
        logic [3:0] li;
        logic [3:0] hi;
        li = low_page_index(i_io_addr);
        hi = high_page_index(i_io_addr);
        next_state = state;
        next_state.rdata = dpt_pkg::READ_UNDEFINED;
        next_state.hit = 1'b0;
        if (i_io_write && li != 4'h8) begin
            next_state.low_page[li[2:0]] = i_io_wdata; // R6
        end
        if (i_io_write && hi != 4'h8) begin
            next_state.high_page[hi[2:0]] = i_io_wdata; // R6
        end
        if (i_io_read) begin
            if (li != 4'h8) begin
                next_state.rdata = state.low_page[li[2:0]]; // R6
                next_state.hit   = 1'b1;
            end else if (hi != 4'h8) begin
                next_state.rdata = state.high_page[hi[2:0]]; // R6
                next_state.hit   = 1'b1;
            end
            // Timing registers are not decoded for reads, so software sees zero.
        end
        // The pages are held while idle so the address bus does not toggle needlessly.
        if (i_transfer_active) begin
            next_state.addr_high = {state.high_page[i_active_channel], // R2
                                    state.low_page[i_active_channel]}; // R1
        end
    end

    // Synchronous reset of the page registers to zero.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            state <= '{low_page: {NUM_CH{dpt_pkg::PAGE_RESET}},
                       high_page: {NUM_CH{dpt_pkg::PAGE_RESET}},
                       rdata: dpt_pkg::READ_UNDEFINED, hit: 1'b0,
                       addr_high: {2{dpt_pkg::PAGE_RESET}}}; // R6
        end else begin
            state <= next_state;
        end
    end

    // Byte-wide unit covers channels 0 to 3.
    dpt_timing_unit u_byte_timing (
        .I_SYS_CLK        (I_SYS_CLK),
        .i_reset          (ext_reset),
        .i_write          (byte_ext_write),
        .i_data           (i_io_wdata),
        .o_select         (o_byte_wide_dma_unit_select), // R10
        .o_mode           (o_byte_wide_dma_unit_mode),
        .o_channel_timing (o_channel_timing[7:0])
    );

    // Word-wide unit covers channels 4 to 7.
    dpt_timing_unit u_word_timing (
        .I_SYS_CLK        (I_SYS_CLK),
        .i_reset          (ext_reset),
        .i_write          (word_ext_write),
        .i_data           (i_io_wdata),
        .o_select         (o_word_wide_dma_unit_select), // R11
        .o_mode           (o_word_wide_dma_unit_mode),
        .o_channel_timing (o_channel_timing[15:8])
    );

    assign o_io_rdata      = state.rdata;
    assign o_io_hit        = state.hit;
    assign o_dma_addr_high = state.addr_high;

endmodule : dpt_regs

// ---- verification/dpt_regs_monitor.sv ----
// Checker for the DMA page and cycle timing register bank.
// Sees only the top ports of dpt_regs and is bound into every instance.
`timescale 1ns/1ns
module dpt_regs_monitor #(
    parameter int NUM_CH = 8
) (
    input wire logic                 I_SYS_CLK,
    input wire logic                 I_SYS_RST,
    input wire logic                 i_host_processor_reset,
    input wire logic [15:0]          i_io_addr,
    input wire logic                 i_io_write,
    input wire logic                 i_io_read,
    input wire logic [7:0]           i_io_wdata,
    input wire logic [2:0]           i_active_channel,
    input wire logic                 i_transfer_active,
    input wire logic [7:0]           o_io_rdata,
    input wire logic                 o_io_hit,
    input wire logic [15:0]          o_dma_addr_high,
    input wire logic [3:0]           o_byte_wide_dma_unit_select,
    input wire dpt_pkg::dpt_timing_t o_byte_wide_dma_unit_mode,
    input wire logic [3:0]           o_word_wide_dma_unit_select,
    input wire dpt_pkg::dpt_timing_t o_word_wide_dma_unit_mode,
    input wire logic [2*NUM_CH-1:0]  o_channel_timing
);
    // Everything here lives in the one clock domain and sleeps in reset.
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    // Reads of the write-only timing registers must stay silent.
    a_ext_read_quiet: assert property (i_io_read && i_io_addr inside {16'h040B, 16'h04D6}
        |=> !o_io_hit && o_io_rdata == 8'h00) else $error("timing register read answered");
    a_low_page_hit: assert property (i_io_read && i_io_addr inside {[16'h0089:16'h008B]}
        |=> o_io_hit) else $error("word low page read not decoded");
    a_high_page_hit: assert property (i_io_read && i_io_addr inside {[16'h0481:16'h0483],
        16'h0487, [16'h0489:16'h048B]} |=> o_io_hit) else $error("high page read not decoded");
    a_page_read_back: assert property (i_io_write && !i_io_read && i_io_addr == 16'h0489
        ##1 i_io_read && !i_io_write && i_io_addr == 16'h0489 |=> o_io_rdata == $past(i_io_wdata, 2))
        else $error("page register lost written value");
    // A write that races the processor reset is left out; reset wins there.
    a_byte_ext_fields: assert property (i_io_write && i_io_addr == 16'h040B
        && !i_host_processor_reset |=> {o_byte_wide_dma_unit_mode, o_byte_wide_dma_unit_select}
        == $past(i_io_wdata[5:0])) else $error("byte unit timing fields wrong");
    a_word_ext_fields: assert property (i_io_write && i_io_addr == 16'h04D6
        && !i_host_processor_reset |=> {o_word_wide_dma_unit_mode, o_word_wide_dma_unit_select}
        == $past(i_io_wdata[5:0])) else $error("word unit timing fields wrong");
    a_cpu_reset_clear: assert property (i_host_processor_reset && !i_io_write
        |=> o_byte_wide_dma_unit_select == 4'h0 && o_word_wide_dma_unit_select == 4'h0
        && o_byte_wide_dma_unit_mode == dpt_pkg::DPT_TIMING_COMPAT
        && o_word_wide_dma_unit_mode == dpt_pkg::DPT_TIMING_COMPAT
        && o_channel_timing == '0) else $error("processor reset left timing set");
    // The page address only follows the channel while a transfer runs.
    a_addr_idle_hold: assert property (!i_transfer_active |=> $stable(o_dma_addr_high))
        else $error("page address moved while idle");
    a_select_applies: assert property (i_io_write && i_io_addr == 16'h040B && i_io_wdata[0]
        && !i_io_wdata[1] && !i_host_processor_reset |=> o_channel_timing[1:0]
        == $past(i_io_wdata[5:4]) && $stable(o_channel_timing[3:2])) else $error("select ignored");

    // Main scenarios the bench is expected to reach.
    c_page_hit: cover property (o_io_hit);
    c_word_ext_write: cover property (i_io_write && i_io_addr == 16'h04D6);
    c_cpu_reset: cover property (i_host_processor_reset);
endmodule : dpt_regs_monitor

bind dpt_regs dpt_regs_monitor #(.NUM_CH(NUM_CH)) u_monitor (.*);

// ---- verification/testbench.sv ----
// Self-checking bench for the DMA page and cycle timing register bank.
// Drives the I/O strobes directly; a reference model in arrays sets expectations.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    logic                 clk  = 1'h0;
    logic                 rst  = 1'h1;
    logic                 cpu  = 1'h0;
    logic [15:0]          addr = 16'h0000;
    logic                 wr   = 1'h0;
    logic                 rd   = 1'h0;
    logic [7:0]           wd   = 8'h00;
    logic [2:0]           ach  = 3'h0;
    logic                 act  = 1'h0;
    logic [7:0]           rdata;
    logic                 hit;
    logic [15:0]          dah;
    logic [3:0]           bs, ws;
    dpt_pkg::dpt_timing_t bm, wm;
    logic [15:0]          ct;
    logic [7:0]           lo[8], hi[8];
    logic [1:0]           tm[8];
    logic [5:0]           bx, wx;
    int                   bad_count = 0;
    int                   total_checks = 0;
    int                   cyc = 0;
    // Low page addresses by channel; channel 4 has none, so FFFF stands unmapped.
    logic [15:0] la[8] = '{16'h0087, 16'h0083, 16'h0081, 16'h0082,
                           16'hFFFF, 16'h008B, 16'h0089, 16'h008A};

    dpt_regs dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .i_host_processor_reset(cpu),
        .i_io_addr(addr), .i_io_write(wr), .i_io_read(rd), .i_io_wdata(wd),
        .i_active_channel(ach), .i_transfer_active(act), .o_io_rdata(rdata), .o_io_hit(hit),
        .o_dma_addr_high(dah), .o_byte_wide_dma_unit_select(bs), .o_byte_wide_dma_unit_mode(bm),
        .o_word_wide_dma_unit_select(ws), .o_word_wide_dma_unit_mode(wm), .o_channel_timing(ct));

    // Clock and a cycle ceiling well above the planned run, in case of a hang.
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // Compares every timing output with the model.
    task automatic chk_cfg();
        logic [15:0] x;
        for (int c = 0; c < 8; c++) x[2*c +: 2] = tm[c];
        `CHK(({bm, bs}), bx)
        `CHK(({wm, ws}), wx)
        `CHK(ct, x)
    endtask : chk_cfg

    // One I/O cycle; strobes stay up so back-to-back cycles need no gap.
    task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        logic [8:0] e;
        e = 9'h000;
        for (int c = 0; c < 8; c++) begin
            if (c != 4 && a == la[c]) e = {1'h1, lo[c]};
            if (c != 4 && a == (la[c] | 16'h0400)) e = {1'h1, hi[c]};
        end
        wr = w;
        rd = r;
        addr = a;
        wd = d;
        @(posedge clk);
        #1;
        `CHK(({hit, rdata}), (r ? e : 9'h000))
        for (int c = 0; c < 8; c++) begin
            if (w && c != 4 && a == la[c]) lo[c] = d;
            if (w && c != 4 && a == (la[c] | 16'h0400)) hi[c] = d;
            if (w && a == (c < 4 ? 16'h040B : 16'h04D6) && d[c % 4]) tm[c] = d[5:4];
        end
        if (w && a == 16'h040B) bx = d[5:0];
        if (w && a == 16'h04D6) wx = d[5:0];
        chk_cfg();
    endtask : acc

    task automatic idle();
        wr = 1'h0;
        rd = 1'h0;
        @(posedge clk);
        #1;
    endtask : idle

    // Main sequence: reset values, every timing mode, random traffic, reset, transfers.
    initial begin
        int k;
        void'($urandom(32'hBDE0));
        foreach (lo[c]) begin
            lo[c] = 8'h00;
            hi[c] = 8'h00;
            tm[c] = 2'h0;
        end
        bx = 6'h00;
        wx = 6'h00;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'h0;
        for (int c = 0; c < 16; c++) acc(0, 1, la[c % 8] | (c > 7 ? 16'h0400 : 16'h0000), 8'h00);
        for (int m = 0; m < 4; m++) begin
            acc(1, 0, 16'h040B, {2'h0, 2'(m), 4'(1 << m)});
            acc(1, 0, 16'h04D6, {2'h0, 2'(3 - m), 4'hF ^ 4'(1 << m)});
        end
        acc(1, 0, 16'h0489, 8'hA5);
        acc(0, 1, 16'h0489, 8'h00);
        acc(1, 1, 16'h048B, 8'h3C);
        for (int i = 0; i < 300; i++) begin
            k = $urandom % 18;
            acc(1'($urandom % 2), 1'($urandom % 2), k < 8 ? la[k] : k < 16 ? (la[k - 8] | 16'h0400) :
                k == 16 ? 16'h040B : 16'h04D6, k > 15 ? 8'($urandom % 64) : 8'($urandom));
        end
        idle();
        cpu = 1'h1;
        @(posedge clk);
        #1;
        cpu = 1'h0;
        bx = 6'h00;
        wx = 6'h00;
        foreach (tm[c]) tm[c] = 2'h0;
        chk_cfg();
        // Transfers on every channel; channel 4 has no pages and drives zero.
        act = 1'h1;
        for (int c = 0; c < 8; c++) begin
            ach = 3'(c);
            @(posedge clk);
            #1;
            `CHK(dah, ({hi[c], lo[c]}))
        end
        // Idle: the page address must hold even though the channel number moves.
        act = 1'h0;
        ach = 3'h5;
        @(posedge clk);
        #1;
        `CHK(dah, ({hi[7], lo[7]}))
        // System reset in mid-run clears every page; each one then reads back zero.
        rst = 1'h1;
        @(posedge clk);
        #1;
        rst = 1'h0;
        foreach (lo[c]) begin
            lo[c] = 8'h00;
            hi[c] = 8'h00;
        end
        `CHK(dah, 16'h0000)
        for (int c = 0; c < 16; c++) acc(0, 1, la[c % 8] | (c > 7 ? 16'h0400 : 16'h0000), 8'h00);
        report_and_stop();
    end
endmodule : testbench
